/* core/left_effects_coef_bank.sv */
// left channel effects filter forward coefficient register bank
`timescale 1ns/1ps
`include "coef_bank_defs.svh"
`default_nettype none
// Behaviour
// - first coefficient upper byte at page-one register 3, lower at 4.
// - second coefficient upper byte at page-one register 5, lower at 6.
// - third coefficient upper byte at page-one register 7, lower at 8.
// - fourth coefficient upper byte at page-one register 9, lower at 10.
// - fifth coefficient upper byte at page-one register 11.
// - upper byte above lower byte forms one 16-bit coefficient.
// - each coefficient is two's complement, -32768 to +32767.
// - coefficient bytes clear to zero on reset.
// - all eight bits read and write; a read returns the last write.
module left_effects_coef_bank #(
  parameter int BYTE_W    = `LFX_BYTE_W,
  parameter int FWD_PAIRS = `LFX_FWD_PAIRS
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       active_page,
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [`LFX_ADDR_W-1:0]     reg_addr,
  input  wire logic [BYTE_W-1:0]          reg_wdata,
  output var  logic [BYTE_W-1:0]          reg_rdata,
  output var  logic                       reg_rd_hit,
  output var  logic                       reg_rd_valid,
  output var  logic signed [2*BYTE_W-1:0] fwd1_coef,
  output var  logic signed [2*BYTE_W-1:0] fwd2_coef,
  output var  logic signed [2*BYTE_W-1:0] fwd3_coef,
  output var  logic signed [2*BYTE_W-1:0] fwd4_coef,
  output var  logic [BYTE_W-1:0]          fwd5_coef_high,
  output var  logic [FWD_PAIRS-1:0]       coef_applied,
  output var  logic                       seq_pending,
  output var  logic                       seq_break
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // register map is fixed byte-wide with four full pairs and a fifth upper
  if (BYTE_W != 8) begin : g_bad_width
    $error("coefficient bank needs byte-wide registers");
  end
  if (FWD_PAIRS != 4) begin : g_bad_pairs
    $error("coefficient bank map holds exactly four full pairs");
  end
  // pair codes 0..FWD_PAIRS, the fifth upper included, share one field
  if (FWD_PAIRS >= (1 << $bits(coef_bank_pkg::pair_t))) begin : g_bad_code
    $error("pair code field too narrow for the pair count");
  end
  // the fifth upper byte takes the code just past the full pairs
  if (`LFX_FIFTH_PAIR != FWD_PAIRS) begin : g_bad_fifth
    $error("fifth upper byte code must follow the full pairs");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and the read path

  function automatic coef_bank_pkg::reg_sel_s decode_addr(
    input logic                   page,
    input logic [`LFX_ADDR_W-1:0] addr
  );
    coef_bank_pkg::reg_sel_s sel;
    sel = '0;
    // only page one reaches the bank; page zero uses the same numbers
    if (page == `LFX_COEF_PAGE) begin
      unique case (addr)
        `LFX_FWD1_HIGH_ADDR: sel = '{1'b1, 1'b1, 3'h0};
        `LFX_FWD1_LOW_ADDR:  sel = '{1'b1, 1'b0, 3'h0};
        `LFX_FWD2_HIGH_ADDR: sel = '{1'b1, 1'b1, 3'h1};
        `LFX_FWD2_LOW_ADDR:  sel = '{1'b1, 1'b0, 3'h1};
        `LFX_FWD3_HIGH_ADDR: sel = '{1'b1, 1'b1, 3'h2};
        `LFX_FWD3_LOW_ADDR:  sel = '{1'b1, 1'b0, 3'h2};
        `LFX_FWD4_HIGH_ADDR: sel = '{1'b1, 1'b1, 3'h3};
        `LFX_FWD4_LOW_ADDR:  sel = '{1'b1, 1'b0, 3'h3};
        `LFX_FWD5_HIGH_ADDR: sel = '{1'b1, 1'b1, `LFX_FIFTH_PAIR};
        default:             sel = '0;
      endcase
    end
    return sel;
  endfunction : decode_addr

  coef_bank_pkg::reg_sel_s wr_sel;
  coef_bank_pkg::reg_sel_s rd_sel;

  always_comb begin
    wr_sel = decode_addr(active_page, reg_addr);
    rd_sel = decode_addr(active_page, reg_addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // write strobes per pair

  // one strobe per byte register; a write off page one raises none
  function automatic logic byte_strobe(
    input coef_bank_pkg::reg_sel_s sel,
    input coef_bank_pkg::pair_t    pair,
    input logic                    upper
  );
    return sel.hit && (sel.pair == pair) && (sel.is_high == upper);
  endfunction : byte_strobe

  logic [FWD_PAIRS-1:0] high_wr;
  logic [FWD_PAIRS-1:0] low_wr;
  logic                 fifth_wr;

  for (genvar i = 0; i < FWD_PAIRS; i++) begin : g_strobe
    assign high_wr[i] = reg_wr_en && byte_strobe(wr_sel, 3'(i), 1'b1);
    assign low_wr[i]  = reg_wr_en && byte_strobe(wr_sel, 3'(i), 1'b0);
  end

  always_comb begin
    fifth_wr = reg_wr_en && byte_strobe(wr_sel, `LFX_FIFTH_PAIR, 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // the four full coefficient pairs

  coef_bank_pkg::byte_t        pair_high [FWD_PAIRS];
  coef_bank_pkg::byte_t        pair_low  [FWD_PAIRS];
  logic signed [2*BYTE_W-1:0]  pair_coef [FWD_PAIRS];
  logic [FWD_PAIRS-1:0]        pair_applied;

  for (genvar i = 0; i < FWD_PAIRS; i++) begin : g_pair
    coef_pair_reg #(
      .BYTE_W    (BYTE_W)
    ) u_pair (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .high_wr   (high_wr[i]),
      .low_wr    (low_wr[i]),
      .wdata     (reg_wdata),
      .high_q    (pair_high[i]),
      .low_q     (pair_low[i]),
      .coef_q    (pair_coef[i]),
      .applied_q (pair_applied[i])
    );
  end

  always_comb begin
    fwd1_coef    = pair_coef[0];
    fwd2_coef    = pair_coef[1];
    fwd3_coef    = pair_coef[2];
    fwd4_coef    = pair_coef[3];
    coef_applied = pair_applied;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifth coefficient upper byte

  // its lower byte lives outside this bank, so the upper byte is handed
  // on as soon as it is written; the owner of the lower byte pairs them
  logic [BYTE_W-1:0] fifth_high_q;
  logic [BYTE_W-1:0] fifth_high_d;

  always_comb begin
    fifth_high_d = fifth_wr ? reg_wdata : fifth_high_q;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifth_high_q <= `LFX_COEF_BYTE_RESET;
    end else begin
      fifth_high_q <= fifth_high_d;
    end
  end

  always_comb begin
    fwd5_coef_high = fifth_high_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: one cycle from request to data

  logic [BYTE_W-1:0] rdata_q;
  logic [BYTE_W-1:0] rdata_d;
  logic              rd_hit_q;
  logic              rd_hit_d;
  logic              rd_valid_q;
  logic              rd_valid_d;

  // byte each full pair offers to the read mux, picked by the upper flag
  coef_bank_pkg::byte_t pair_rd [FWD_PAIRS];

  for (genvar i = 0; i < FWD_PAIRS; i++) begin : g_rd
    assign pair_rd[i] = rd_sel.is_high ? pair_high[i] : pair_low[i];
  end

  always_comb begin
    rdata_d    = '0;
    rd_hit_d   = 1'b0;
    rd_valid_d = reg_rd_en;
    // a read that meets a write in the same cycle sees the old value
    if (reg_rd_en && rd_sel.hit) begin
      rd_hit_d = 1'b1;
      if (rd_sel.pair == `LFX_FIFTH_PAIR) begin
        rdata_d = fifth_high_q;
      end else begin
        for (int i = 0; i < FWD_PAIRS; i++) begin
          if (rd_sel.pair == 3'(i)) begin
            rdata_d = pair_rd[i];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q    <= '0;
      rd_hit_q   <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rd_hit_q   <= rd_hit_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  always_comb begin
    reg_rdata    = rdata_q;
    reg_rd_hit   = rd_hit_q;
    reg_rd_valid = rd_valid_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper/lower write sequence watch

  // the bank cannot refuse a badly ordered write, so it stores it anyway
  // and flags the slip for the control logic to report
  coef_bank_pkg::wr_seq_e seq_q;
  coef_bank_pkg::wr_seq_e seq_d;
  coef_bank_pkg::pair_t   staged_q;
  coef_bank_pkg::pair_t   staged_d;
  logic                   pending_q;
  logic                   pending_d;
  logic                   break_q;
  logic                   break_d;

  always_comb begin
    seq_d    = seq_q;
    staged_d = staged_q;
    break_d  = 1'b0;
    if (reg_wr_en && wr_sel.hit) begin
      unique case (seq_q)
        coef_bank_pkg::SEQ_IDLE: begin
          if (wr_sel.is_high) begin
            // the fifth upper has no lower partner here, so it never stages
            if (wr_sel.pair != `LFX_FIFTH_PAIR) begin
              seq_d    = coef_bank_pkg::SEQ_HIGH_STAGED;
              staged_d = wr_sel.pair;
            end
          end else begin
            break_d = 1'b1;
          end
        end
        coef_bank_pkg::SEQ_HIGH_STAGED: begin
          if (!wr_sel.is_high && wr_sel.pair == staged_q) begin
            seq_d = coef_bank_pkg::SEQ_IDLE;
          end else begin
            break_d = 1'b1;
            if (wr_sel.is_high && wr_sel.pair != `LFX_FIFTH_PAIR) begin
              staged_d = wr_sel.pair;
            end else begin
              seq_d = coef_bank_pkg::SEQ_IDLE;
            end
          end
        end
      endcase
    end
    pending_d = (seq_d == coef_bank_pkg::SEQ_HIGH_STAGED);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_q     <= coef_bank_pkg::SEQ_IDLE;
      staged_q  <= '0;
      pending_q <= 1'b0;
      break_q   <= 1'b0;
    end else begin
      seq_q     <= seq_d;
      staged_q  <= staged_d;
      pending_q <= pending_d;
      break_q   <= break_d;
    end
  end

  always_comb begin
    seq_pending = pending_q;
    seq_break   = break_q;
  end

endmodule : left_effects_coef_bank
`default_nettype wire

/* core/coef_bank_defs.svh */
// offsets, reset values and counts of the left forward coefficient bank
`ifndef COEF_BANK_DEFS_SVH
`define COEF_BANK_DEFS_SVH

// page on which the coefficient bank answers
`define LFX_COEF_PAGE        1'b1

// register numbers on that page
`define LFX_FWD1_HIGH_ADDR   7'h03
`define LFX_FWD1_LOW_ADDR    7'h04
`define LFX_FWD2_HIGH_ADDR   7'h05
`define LFX_FWD2_LOW_ADDR    7'h06
`define LFX_FWD3_HIGH_ADDR   7'h07
`define LFX_FWD3_LOW_ADDR    7'h08
`define LFX_FWD4_HIGH_ADDR   7'h09
`define LFX_FWD4_LOW_ADDR    7'h0a
`define LFX_FWD5_HIGH_ADDR   7'h0b

// reset value of every coefficient byte
`define LFX_COEF_BYTE_RESET  8'h00

// pair numbering: pairs 0..3 are full coefficients, 4 is the fifth upper
`define LFX_FIFTH_PAIR       3'h4

// structural counts
`define LFX_BYTE_W           8
`define LFX_FWD_PAIRS        4
`define LFX_ADDR_W           7

`endif

/* core/coef_bank_pkg.sv */
// types shared by the left forward coefficient bank
`default_nettype none
package coef_bank_pkg;

  typedef logic [7:0]         byte_t;
  typedef logic signed [15:0] coef_t;
  typedef logic [2:0]         pair_t;

  // decoded register access
  typedef struct packed {
    logic  hit;
    logic  is_high;
    pair_t pair;
  } reg_sel_s;

  // upper/lower write sequence tracking
  typedef enum logic {
    SEQ_IDLE,
    SEQ_HIGH_STAGED
  } wr_seq_e;

endpackage : coef_bank_pkg
`default_nettype wire

/* core/coef_pair_reg.sv */
// one coefficient: upper and lower byte registers plus applied 16-bit value
`timescale 1ns/1ps
`include "coef_bank_defs.svh"
`default_nettype none
module coef_pair_reg #(
  parameter int BYTE_W = `LFX_BYTE_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  high_wr,
  input  wire logic                  low_wr,
  input  wire logic [BYTE_W-1:0]     wdata,
  output var  logic [BYTE_W-1:0]     high_q,
  output var  logic [BYTE_W-1:0]     low_q,
  output var  logic signed [2*BYTE_W-1:0] coef_q,
  output var  logic                  applied_q
);

  logic [BYTE_W-1:0]        high_d;
  logic [BYTE_W-1:0]        low_d;
  logic signed [2*BYTE_W-1:0] coef_d;
  logic                     applied_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    high_d    = high_wr ? wdata : high_q;
    low_d     = low_wr ? wdata : low_q;
    coef_d    = coef_q;
    applied_d = 1'b0;
    // the datapath never sees a half-written value: only the lower write
    // moves the pair across, together with the already held upper byte
    if (low_wr) begin
      coef_d    = $signed({high_q, wdata});
      applied_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_q    <= `LFX_COEF_BYTE_RESET;
      low_q     <= `LFX_COEF_BYTE_RESET;
      coef_q    <= '0;
      applied_q <= 1'b0;
    end else begin
      high_q    <= high_d;
      low_q     <= low_d;
      coef_q    <= coef_d;
      applied_q <= applied_d;
    end
  end

endmodule : coef_pair_reg
`default_nettype wire

/* test/coef_bank_props.sv */
// port assertions for the left forward coefficient bank
`timescale 1ns/1ps
`default_nettype none
module coef_bank_props #(
  parameter int BYTE_W    = 8,
  parameter int FWD_PAIRS = 4
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       active_page,
  input wire logic                       reg_wr_en,
  input wire logic                       reg_rd_en,
  input wire logic [6:0]                 reg_addr,
  input wire logic [BYTE_W-1:0]          reg_wdata,
  input wire logic [BYTE_W-1:0]          reg_rdata,
  input wire logic                       reg_rd_hit,
  input wire logic                       reg_rd_valid,
  input wire logic signed [2*BYTE_W-1:0] fwd1_coef,
  input wire logic signed [2*BYTE_W-1:0] fwd2_coef,
  input wire logic signed [2*BYTE_W-1:0] fwd3_coef,
  input wire logic signed [2*BYTE_W-1:0] fwd4_coef,
  input wire logic [BYTE_W-1:0]          fwd5_coef_high,
  input wire logic [FWD_PAIRS-1:0]       coef_applied,
  input wire logic                       seq_pending,
  input wire logic                       seq_break
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic wr_p = reg_wr_en & active_page;
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  a_miss_zero: assert property (reg_rd_en && !active_page |=>
    !reg_rd_hit && reg_rdata == 8'h00) else $error("page zero read hit");
  a_hit_fwd2: assert property (reg_rd_en && active_page &&
    reg_addr == 7'h05 |=> reg_rd_hit) else $error("register 5 missed");
  a_upper_holds: assert property (wr_p && reg_addr == 7'h03 |=>
    $stable(fwd1_coef) && seq_pending) else $error("upper write applied");
  a_lower_one: assert property (wr_p && reg_addr == 7'h04 |=>
    coef_applied[0] && fwd1_coef[7:0] == $past(reg_wdata))
    else $error("first lower not applied");
  a_lower_three: assert property (wr_p && reg_addr == 7'h08 |=>
    coef_applied[2] && fwd3_coef[7:0] == $past(reg_wdata))
    else $error("third lower not applied");
  a_lower_four: assert property (wr_p && reg_addr == 7'h0a |=>
    coef_applied[3] && fwd4_coef[7:0] == $past(reg_wdata))
    else $error("fourth lower not applied");
  a_fifth_high: assert property (wr_p && reg_addr == 7'h0b |=>
    fwd5_coef_high == $past(reg_wdata)) else $error("fifth upper wrong");
  a_lone_lower: assert property (wr_p && reg_addr == 7'h04 &&
    !seq_pending |=> seq_break) else $error("lone lower write not flagged");
  a_idle_quiet: assert property (!reg_wr_en |=> coef_applied == 4'h0)
    else $error("apply without write");
  c_apply: cover property (wr_p && reg_addr == 7'h04);
  c_break: cover property (seq_break);
  c_fifth: cover property (reg_rd_en && reg_addr == 7'h0b);
endmodule : coef_bank_props
`default_nettype wire

/* test/coef_host.sv */
// host controller model on the coefficient register port
`timescale 1ns/1ps
`default_nettype none
module coef_host (
  input  wire logic       core_clk,
  output var  logic       active_page,
  output var  logic       reg_wr_en,
  output var  logic       reg_rd_en,
  output var  logic [6:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_hit
);
  initial begin
    active_page = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  task automatic page(input logic p);
    @(posedge core_clk);
    #1 active_page = p;
  endtask : page
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    // released lines carry no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : put
  task automatic get(input logic [6:0] a, output logic [7:0] d,
                     output logic h);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
    h = reg_rd_hit;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask : get
endmodule : coef_host
`default_nettype wire

/* test/tb_left_effects_coef_bank.sv */
// self-checking bench for the left forward coefficient bank
`timescale 1ns/1ps
`default_nettype none
module tb_left_effects_coef_bank;
  logic core_clk, sys_rst, active_page, reg_wr_en, reg_rd_en, rd_h;
  logic reg_rd_hit, reg_rd_valid, seq_pending, seq_break;
  logic [6:0]  reg_addr;
  logic [3:0]  coef_applied;
  logic [7:0]  reg_wdata, reg_rdata, fwd5_coef_high, rd_d, hi [5], lo [4];
  logic [15:0] app [4], v;
  logic [15:0] corner [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
  coef_bank_pkg::coef_t fwd1_coef, fwd2_coef, fwd3_coef, fwd4_coef;
  int n_mismatch, checks, cyc, p;
  left_effects_coef_bank dut (.core_clk, .sys_rst, .active_page,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_hit,
    .reg_rd_valid, .fwd1_coef, .fwd2_coef, .fwd3_coef, .fwd4_coef,
    .fwd5_coef_high, .coef_applied, .seq_pending, .seq_break);
  coef_host host (.core_clk, .active_page, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_hit);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [15:0] got_coef(input int i);
    case (i)
      0: return fwd1_coef;
      1: return fwd2_coef;
      2: return fwd3_coef;
      default: return fwd4_coef;
    endcase
  endfunction : got_coef
  function automatic logic [7:0] exp_reg(input int r);
    return r[0] ? hi[(r-3)/2] : lo[(r-4)/2];
  endfunction : exp_reg
  // model follows every write; a lower write applies the held upper
  task automatic wr(input int r, input logic [7:0] d);
    host.put(7'(r), d);
    if (r[0]) hi[(r-3)/2] = d;
    else begin
      lo[(r-4)/2] = d;
      app[(r-4)/2] = {hi[(r-4)/2], d};
    end
  endtask : wr
  task automatic check_all();
    for (int i = 0; i < 4; i++) chk(got_coef(i), app[i]);
    chk({8'h00, fwd5_coef_high}, {8'h00, hi[4]});
    for (int r = 3; r < 12; r++) begin
      host.get(7'(r), rd_d, rd_h);
      chk({6'h00, reg_rd_valid, rd_h, rd_d},
          {6'h00, 2'b11, exp_reg(r)});
    end
  endtask : check_all
  task automatic zero_model();
    hi = '{default: 8'h00};
    lo = '{default: 8'h00};
    app = '{default: 16'h0000};
  endtask : zero_model
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    sys_rst = 1'b1;
    void'($urandom(50));
    zero_model();
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk({10'h000, seq_break, seq_pending, coef_applied}, 16'h0000);
    check_all();
    for (int k = 0; k < 40; k++) begin
      p = k % 4;
      v = (k < 4) ? corner[k] : 16'($urandom);
      wr(2*p+3, v[15:8]);
      chk({14'h0000, seq_break, seq_pending}, 16'h0001);
      wr(2*p+4, v[7:0]);
      chk(got_coef(p), v);
      chk({10'h000, seq_break, seq_pending, coef_applied},
          {10'h000, 2'b00, 4'h1 << p});
    end
    check_all();
    // lone upper write must stay off the datapath
    wr(7, 8'($urandom));
    chk({14'h0000, seq_break, seq_pending}, 16'h0001);
    wr(11, 8'($urandom));
    chk({14'h0000, seq_break, seq_pending}, 16'h0002);
    // lone lower write is stored and applied with the held upper, but flagged
    wr(4, 8'($urandom));
    chk({14'h0000, seq_break, seq_pending}, 16'h0002);
    check_all();
    host.page(1'b0);
    host.put(7'h03, 8'ha5);
    host.get(7'h03, rd_d, rd_h);
    chk({6'h00, reg_rd_valid, rd_h, rd_d}, 16'h0200);
    host.page(1'b1);
    host.get(7'h0c, rd_d, rd_h);
    chk({6'h00, reg_rd_valid, rd_h, rd_d}, 16'h0200);
    check_all();
    // leave an upper byte staged so the reset has state to clear
    wr(3, 8'($urandom));
    @(posedge core_clk);
    #1 sys_rst = 1'b1;
    @(posedge core_clk);
    #1 sys_rst = 1'b0;
    zero_model();
    chk({10'h000, seq_break, seq_pending, coef_applied}, 16'h0000);
    check_all();
    wrap_up();
  end
endmodule : tb_left_effects_coef_bank
bind left_effects_coef_bank coef_bank_props #(.BYTE_W(BYTE_W),
  .FWD_PAIRS(FWD_PAIRS)) props (.core_clk, .sys_rst, .active_page,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_hit,
  .reg_rd_valid, .fwd1_coef, .fwd2_coef, .fwd3_coef, .fwd4_coef,
  .fwd5_coef_high, .coef_applied, .seq_pending, .seq_break);
`default_nettype wire
